// ===== hdl/dac_out_ctrl.sv
// module: register file, conversion start and pin routing for two 8-bit converter channels
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// Function
// - data write starts a new conversion
// - pin driven only while enable is 1
// - output stays until enable cleared
// - 8-bit code feeds 8-bit ladder
// - level is vref/256 times code
// - adc reference bit never gates output
// - two independent channels with own resources
// - shared pins float as inputs after reset
module dac_out_ctrl (
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  input  wire logic                clk_en,
  input  wire dac_pkg::dac_req_t   req,
  output logic [7:0]               rdata,
  output logic [7:0]               ladder_code_ch0,
  output logic [7:0]               ladder_code_ch1,
  output logic                     analog_out_ch0_en,
  output logic                     analog_out_ch1_en,
  output logic                     conv_busy_ch0,
  output logic                     conv_busy_ch1
);
  import dac_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  // all state lives in one struct so a freeze or reset reaches every bit
  dac_state_t st_r;
  dac_state_t st_nxt;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic hit_data0;
  logic hit_data1;
  logic hit_ctrl;
  logic hit_status;

  // one hit at most; unmapped offsets hit nothing, so writes there vanish
  always_comb begin
    hit_data0  = 1'b0;
    hit_data1  = 1'b0;
    hit_ctrl   = 1'b0;
    hit_status = 1'b0;
    if (req.addr == ADDR_DATA0) begin
      hit_data0 = 1'b1;
    end else if (req.addr == ADDR_DATA1) begin
      hit_data1 = 1'b1;
    end else if (req.addr == ADDR_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (req.addr == ADDR_STATUS) begin
      hit_status = 1'b1;
    end
  end

  // ----------------------------------------
  // strobes per target
  // ----------------------------------------
  logic [NUM_CH-1:0] wr_code;
  logic              wr_ctrl;
  logic [NUM_CH-1:0] rd_code;
  logic              rd_ctrl;
  logic              rd_status;

  assign wr_code[0] = req.wr && hit_data0;
  assign wr_code[1] = req.wr && hit_data1;
  assign wr_ctrl    = req.wr && hit_ctrl;
  assign rd_code[0] = req.rd && hit_data0;
  assign rd_code[1] = req.rd && hit_data1;
  assign rd_ctrl    = req.rd && hit_ctrl;
  assign rd_status  = req.rd && hit_status;

  // ----------------------------------------
  // enable bits carried by a control write
  // ----------------------------------------
  logic [NUM_CH-1:0] en_wdata;

  assign en_wdata[0] = req.wdata[CTRL_EN0_BIT];
  assign en_wdata[1] = req.wdata[CTRL_EN1_BIT];

  // ----------------------------------------
  // settle counters
  // ----------------------------------------
  // busy is a fixed timer only; the ladder's real settling is not observed
  logic [NUM_CH-1:0][8:0] cnt_dec;
  logic [NUM_CH-1:0]      cnt_live;
  logic [NUM_CH-1:0]      busy_tail;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_settle
    assign cnt_live[g]  = (st_r.ch[g].cnt != 9'h000);
    assign cnt_dec[g]   = cnt_live[g] ? (st_r.ch[g].cnt - 9'h001) : 9'h000;
    assign busy_tail[g] = (st_r.ch[g].cnt > 9'h001);
  end

  // ----------------------------------------
  // control and status words
  // ----------------------------------------
  logic [7:0] ctrl_word;
  logic [7:0] status_word;

  assign ctrl_word   = {6'h00, st_r.ch[1].oe, st_r.ch[0].oe};
  assign status_word = {6'h00, st_r.ch[1].busy, st_r.ch[0].busy};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // no adc reference input exists here by design, so it cannot touch the path
  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = 8'h00;

    for (int i = 0; i < NUM_CH; i++) begin
      st_nxt.ch[i].cnt  = cnt_dec[i];
      st_nxt.ch[i].busy = busy_tail[i];
      if (wr_code[i]) begin
        st_nxt.ch[i].code = req.wdata;
        st_nxt.ch[i].cnt  = SETTLE_LOAD;
        st_nxt.ch[i].busy = 1'b1;
      end
      // enable holds until software writes it back to 0
      if (wr_ctrl) begin
        st_nxt.ch[i].oe = en_wdata[i];
      end
    end

    // read data stands one cycle, then drops back to zero
    if (rd_code[0]) begin
      st_nxt.rdata = st_r.ch[0].code;
    end else if (rd_code[1]) begin
      st_nxt.rdata = st_r.ch[1].code;
    end else if (rd_ctrl) begin
      st_nxt.rdata = ctrl_word;
    end else if (rd_status) begin
      st_nxt.rdata = status_word;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        st_r.ch[i].code <= DATA_RST;
        st_r.ch[i].oe   <= EN_RST[i];
        st_r.ch[i].busy <= 1'b0;
        st_r.ch[i].cnt  <= 9'h000;
      end
      st_r.rdata <= 8'h00;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // ladder gives vref/256 per code step; pin drive gated by enable only
  assign ladder_code_ch0   = st_r.ch[0].code;
  assign ladder_code_ch1   = st_r.ch[1].code;
  assign analog_out_ch0_en = st_r.ch[0].oe;
  assign analog_out_ch1_en = st_r.ch[1].oe;
  assign conv_busy_ch0     = st_r.ch[0].busy;
  assign conv_busy_ch1     = st_r.ch[1].busy;
  assign rdata             = st_r.rdata;

endmodule

// ===== shared/dac_pkg.sv
// package: constants and carrier types for the two-channel converter control block
package dac_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int unsigned NUM_CH    = 2;
  localparam int unsigned CODE_W    = 8;
  localparam int unsigned LADDER_DIV = 256;  // full scale divisor: level = vref / 256 * code

  // ----------------------------------------
  // register offsets and fields
  // ----------------------------------------
  localparam logic [3:0] ADDR_DATA0  = 4'h0;
  localparam logic [3:0] ADDR_DATA1  = 4'h1;
  localparam logic [3:0] ADDR_CTRL   = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam int unsigned CTRL_EN0_BIT = 0;
  localparam int unsigned CTRL_EN1_BIT = 1;

  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] EN_RST   = 2'h0;
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned SETTLE_US    = 3;
  localparam int unsigned SETTLE_CYC   = SETTLE_US * CLK_MHZ;
  localparam logic [8:0]  SETTLE_LOAD  = 9'(SETTLE_CYC);

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dac_req_t;

  typedef struct packed {
    logic [7:0] code;
    logic       oe;
    logic       busy;
    logic [8:0] cnt;
  } dac_ch_t;

  typedef struct packed {
    dac_ch_t [NUM_CH-1:0] ch;
    logic [7:0]           rdata;
  } dac_state_t;

endpackage

// ===== bench/dac_pin_model.sv
// model: level seen on a shared pin by the outside circuit, in millivolts
`timescale 1ns/1ps
module dac_pin_model #(parameter int VREF_MV = 5120) (
  input  wire logic [7:0] code,
  input  wire logic       en,
  output int              level_mv
);
  // -1 marks a floating pin, so a released pin never shows a stale level
  // the outside circuit only listens; the shared pin's port side stays an input
  assign level_mv = en ? VREF_MV * code / 256 : -1;
endmodule

// ===== bench/dac_out_ctrl_properties.sv
// checker: port relations of the converter control block
`timescale 1ns/1ps
module dac_out_ctrl_properties (
  input wire logic              core_clk, arst_n, clk_en,
  input wire dac_pkg::dac_req_t req,
  input wire logic [7:0]        rdata, ladder_code_ch0, ladder_code_ch1,
  input wire logic              analog_out_ch0_en, analog_out_ch1_en, conv_busy_ch0, conv_busy_ch1
);
  import dac_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire w0 = clk_en && req.wr && req.addr == ADDR_DATA0;
  wire w1 = clk_en && req.wr && req.addr == ADDR_DATA1;
  wire wc = clk_en && req.wr && req.addr == ADDR_CTRL;
  wire [1:0] en = {analog_out_ch1_en, analog_out_ch0_en};
  logic [9:0] age0;
  // cycles since the last taken data write on channel 0, frozen with the block
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) age0 <= 10'h3ff;
    else if (w0) age0 <= 10'h000;
    else if (clk_en && age0 != 10'h3ff) age0 <= age0 + 10'h001;
  end
  sequence ctrl_rd_s;
    clk_en && req.rd && req.addr == ADDR_CTRL;
  endsequence
  busy_len_a: assert property (conv_busy_ch0 == (age0 < SETTLE_CYC)) else $error("busy length");
  rd_idle_a: assert property (clk_en && !req.rd |=> rdata == 8'h00) else $error("rdata idle");
  code_load_a: assert property (w0 |=> ladder_code_ch0 == $past(req.wdata)) else $error("code0");
  code1_load_a: assert property (w1 |=> ladder_code_ch1 == $past(req.wdata)) else $error("code1");
  busy_start_a: assert property (w0 |=> conv_busy_ch0) else $error("busy");
  en_set_a: assert property (wc |=> en == $past(req.wdata[1:0])) else $error("en");
  en_hold_a: assert property (!wc |=> $stable(en)) else $error("en hold");
  chan_iso_a: assert property (w1 |=> $stable(ladder_code_ch0)) else $error("iso");
  ctrl_read_a: assert property (ctrl_rd_s |=> rdata == {6'h0, en}) else $error("rd");
  reset_clear_a: assert property ($rose(arst_n) |-> !en && !ladder_code_ch0 && !ladder_code_ch1) else $error("rst");
endmodule

// ===== bench/testbench.sv
// bench: register traffic, output codes and pin levels
`timescale 1ns/1ps
module testbench;
  import dac_pkg::*;
  logic       core_clk = 0, arst_n = 0, clk_en = 1;
  dac_req_t   req = '0;
  logic [7:0] rdata, c0, c1;
  logic       e0, e1, b0, b1;
  int         lv0, lv1, n_errors = 0, n_checks = 0;
  // rows: addr, wdata, code0, code1, enables
  logic [31:0] row [6] = '{32'h0ffff000, 32'h180ff800, 32'h201ff801, 32'h202ff802, 32'h00000802, 32'h20300803};
  dac_out_ctrl DUT (.core_clk, .arst_n, .clk_en, .req, .rdata, .ladder_code_ch0(c0), .ladder_code_ch1(c1),
    .analog_out_ch0_en(e0), .analog_out_ch1_en(e1), .conv_busy_ch0(b0), .conv_busy_ch1(b1));
  dac_pin_model m0 (.code(c0), .en(e0), .level_mv(lv0));
  dac_pin_model m1 (.code(c1), .en(e1), .level_mv(lv1));
  always #5 core_clk = ~core_clk;
  task chk(string s, logic [19:0] g, x);
    n_checks++;
    if (g !== x) begin
      n_errors++;
      $display("Error %s exp %h saw %h", s, x, g);
    end
  endtask
  task bus(logic [3:0] a, logic [7:0] d, logic w);
    @(posedge core_clk) req <= '{a, d, w, !w};
    @(posedge core_clk) req <= '0;
    #1;
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1;
    foreach (row[i]) begin
      bus(row[i][31:28], row[i][27:20], 1);
      chk("out", {c0, c1, 2'h0, e1, e0}, row[i][19:0]);
      chk("lvl", lv0, row[i][0] ? row[i][19:12] * (5120 / 256) : -1);
      bus(ADDR_CTRL, 0, 0);
      chk("ctl", rdata, row[i][1:0]);
    end
    chk("bs0", b0, 1);
    bus(4'h7, 8'h33, 1);
    bus(4'h7, 0, 0);
    chk("unm", rdata, 0);
    @(posedge core_clk) clk_en <= 0;
    bus(ADDR_DATA1, 8'h11, 1);
    chk("frz", c1, 8'h80);
    @(posedge core_clk) clk_en <= 1;
    bus(ADDR_DATA1, 8'h44, 1);
    bus(ADDR_STATUS, 0, 0);
    chk("sts", rdata[1], 1);
    repeat (300) @(posedge core_clk);
    #1 chk("bsy", b1, 0);
    @(posedge core_clk) arst_n <= 0;
    #20 chk("rst", {c0, c1, e1, e0, lv1[1:0]}, 20'h00003);
    @(posedge core_clk) arst_n <= 1;
    bus(ADDR_DATA0, 8'h5a, 1);
    chk("aft", c0, 8'h5a);
    print_verdict;
  end
  initial begin
    #20us n_errors++;
    print_verdict;
  end
endmodule
bind dac_out_ctrl dac_out_ctrl_properties chk_i (.core_clk, .arst_n, .clk_en, .req, .rdata, .ladder_code_ch0,
  .ladder_code_ch1, .analog_out_ch0_en, .analog_out_ch1_en, .conv_busy_ch0, .conv_busy_ch1);
